// File: lpw_pkg.sv
// Purpose: shared types and constants for the low-power wake and vectoring block
// Assumes: one clock, the oscillator reference clock, at 250 MHz
// Notes:   interrupt index order is also the fixed wake priority, index 0 highest
package lpw_pkg;

  // mode sequencer, one-hot
  typedef enum logic [6:0] {
    MODE_RUN      = 7'h01,
    MODE_WAIT     = 7'h02,
    MODE_STOP     = 7'h04,
    MODE_RECOVER  = 7'h08,
    MODE_FETCH_HI = 7'h10,
    MODE_FETCH_LO = 7'h20,
    MODE_CAPTURE  = 7'h40
  } mode_e_t;

  // interrupt source indices, lower index wins
  localparam int NUM_INT     = 17;
  localparam int IDX_BREAK   = 0;
  localparam int IDX_IRQ     = 1;
  localparam int IDX_CGU     = 2;
  localparam int IDX_T1_CH0  = 3;
  localparam int IDX_T1_CH1  = 4;
  localparam int IDX_T1_OVF  = 5;
  localparam int IDX_T2_CH0  = 6;
  localparam int IDX_T2_CH1  = 7;
  localparam int IDX_T2_OVF  = 8;
  localparam int IDX_SPI_RX  = 9;
  localparam int IDX_SPI_TX  = 10;
  localparam int IDX_SCI_ERR = 11;
  localparam int IDX_SCI_RX  = 12;
  localparam int IDX_SCI_TX  = 13;
  localparam int IDX_KBD     = 14;
  localparam int IDX_ADC     = 15;
  localparam int IDX_PWT     = 16;

  // vector pair addresses, the even byte is the high byte
  localparam logic [15:0] VEC_RESET = 16'hFFFE;
  localparam logic [15:0] VEC_BREAK = 16'hFFFC;
  localparam logic [15:0] VEC_IRQ   = 16'hFFFA;
  localparam logic [15:0] VEC_CGU   = 16'hFFF8;
  localparam logic [15:0] VEC_T1_CH0  = 16'hFFF6;
  localparam logic [15:0] VEC_T1_CH1  = 16'hFFF4;
  localparam logic [15:0] VEC_T1_OVF  = 16'hFFF2;
  localparam logic [15:0] VEC_T2_CH0  = 16'hFFF0;
  localparam logic [15:0] VEC_T2_CH1  = 16'hFFEE;
  localparam logic [15:0] VEC_T2_OVF  = 16'hFFEC;
  localparam logic [15:0] VEC_SPI_RX  = 16'hFFEA;
  localparam logic [15:0] VEC_SPI_TX  = 16'hFFE8;
  localparam logic [15:0] VEC_SCI_ERR = 16'hFFE6;
  localparam logic [15:0] VEC_SCI_RX  = 16'hFFE4;
  localparam logic [15:0] VEC_SCI_TX  = 16'hFFE2;
  localparam logic [15:0] VEC_KBD     = 16'hFFE0;
  localparam logic [15:0] VEC_ADC     = 16'hFFDE;
  localparam logic [15:0] VEC_PWT     = 16'hFFDC;

  localparam logic [NUM_INT-1:0][15:0] INT_VEC_TABLE = {
    VEC_PWT, VEC_ADC, VEC_KBD, VEC_SCI_TX, VEC_SCI_RX, VEC_SCI_ERR,
    VEC_SPI_TX, VEC_SPI_RX, VEC_T2_OVF, VEC_T2_CH1, VEC_T2_CH0,
    VEC_T1_OVF, VEC_T1_CH1, VEC_T1_CH0, VEC_CGU, VEC_IRQ, VEC_BREAK};

  // sources able to end stop mode: break, irq pin, keypad pin, periodic timer
  localparam logic [NUM_INT-1:0] STOP_WAKE_MASK = 17'h1_4003;

  // stop recovery hold-off, in reference clock cycles
  localparam int REC_LONG_CYC  = 4096;
  localparam int REC_SHORT_CYC = 32;
  localparam logic [11:0] REC_LONG_LOAD  = 12'(REC_LONG_CYC - 1);
  localparam logic [11:0] REC_SHORT_LOAD = 12'(REC_SHORT_CYC - 1);

  // reset values
  localparam logic       RST_INT_MASK = 1'b1;
  localparam logic       RST_PIN_IDLE = 1'b1;

  // module interrupt requests, each a level held by its source
  typedef struct packed {
    logic       break_req;
    logic       cgu_req;
    logic       kbd_req;
    logic [2:0] first_timer_req;     // 2 overflow, 1 channel 1, 0 channel 0
    logic [2:0] second_timer_req;     // 2 overflow, 1 channel 1, 0 channel 0
    logic [1:0] spi_req;      // 1 receiver, 0 transmitter
    logic [2:0] sci_req;      // 2 receive error, 1 receiver, 0 transmitter
    logic       adc_req;
    logic       wdog_timeout;
    logic       lvr_req;
  } wake_src_t;

  // vector fetch request to program memory
  typedef struct packed {
    logic        rd;
    logic [15:0] addr;
  } fetch_t;

endpackage : lpw_pkg

// File: pin_sync3.sv
// Purpose: three-stage synchroniser with agreement filter for pin inputs
// Assumes: inputs asynchronous to i_clk
// Notes:   output changes only when stages two and three agree
`timescale 1ns/100ps
`default_nettype none

module pin_sync3 #(
  parameter int            W       = 1,
  parameter logic [W-1:0]  RST_VAL = '1
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  // pins and filtered levels
  input  wire logic [W-1:0] i_pin,
  output logic      [W-1:0] o_level
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] level;
  } sync_st_t;

  sync_st_t st_ff;
  sync_st_t nxt_st;

  always_comb
  begin
    nxt_st    = st_ff;
    nxt_st.s1 = i_pin;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    // s1 is seen by s2 alone
    for (int i = 0; i < W; i++)
    begin
      if (st_ff.s2[i] == st_ff.s3[i])
      begin
        nxt_st.level[i] = st_ff.s3[i];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_ff <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign o_level = st_ff.level;

endmodule : pin_sync3

`default_nettype wire

// File: low_power_wake_vectoring.sv
// Purpose: wake from wait and stop, stop recovery delay, and vector fetch into the program counter
// Assumes: vector memory returns i_vec_data one cycle after o_fetch.rd; module requests already enabled
// Notes:   config bits arrive as plain inputs; the periodic wake timer counter lives here
//
// Contract
// - wait-mode wake restarts CPU clock and loads reset or source vector
// - reset pin low resets, loads FFFE/FFFF, ends either low-power mode
// - falling edge on irq pin wakes from wait or stop, vector FFFA
// - break interrupt wakes from wait or stop, vector FFFC
// - watchdog timeout in wait resets, vector FFFE
// - low-voltage reset request resets from wait or stop, vector FFFE
// - clock generator request in wait wakes CPU, vector FFF8
// - keypad selects FFE0: module request in wait, pin falling edge in stop
// - first timer in wait: overflow FFF2, channel 1 FFF4, channel 0 FFF6
// - second timer in wait: overflow FFEC, channel 1 FFEE, channel 0 FFF0
// - SPI in wait: transmitter FFE8, receiver FFEA
// - SCI in wait: transmit FFE2, receive FFE4, receive error FFE6
// - ADC conversion complete in wait wakes CPU, vector FFDE
// - periodic wake timer request wakes from wait, vector FFDC
// - only reset, irq/keypad pin edge, low-voltage, break, periodic timer end stop
// - periodic wake timer interrupts on counter rollover in stop only with osc_run_in_stop, vector FFDC
// - after stop exit, 12-bit counter holds system clocks off 4096 cycles
// - short recovery select shortens stop hold-off to 32 cycles
// - entering wait/stop clears interrupt mask; reset exit sets it
// - timer and clock generator clocks run in stop only with osc_run_in_stop
`timescale 1ns/100ps
`default_nettype none

module low_power_wake_vectoring #(
  parameter int KBD_PINS = 8,
  parameter int PWT_W    = 15
) (
  // clock and reset
  input  wire logic                      i_clk,
  input  wire logic                      i_reset_n,
  // pins, asynchronous
  input  wire logic                      i_reset_pin_n,
  input  wire logic                      i_irq_pin_n,
  input  wire logic [KBD_PINS-1:0]       i_kbd_pin_n,
  // configuration levels
  input  wire logic [KBD_PINS-1:0]       i_kbd_pin_en,
  input  wire logic                      i_short_recovery_select,
  input  wire logic                      i_osc_run_in_stop,
  input  wire logic                      i_pwt_enable,
  // CPU core
  input  wire logic                      i_wait_req,
  input  wire logic                      i_stop_req,
  input  wire logic [7:0]                i_vec_data,
  input  wire lpw_pkg::wake_src_t        i_src,
  output lpw_pkg::fetch_t                o_fetch,
  output logic      [15:0]               o_pc,
  output logic                           o_pc_load,
  output logic                           o_int_mask,
  output logic                           o_core_reset,
  // clock gates and status
  output logic                           o_cpu_clk_en,
  output logic                           o_sys_clk_en,
  output logic                           o_aux_clk_en,
  output logic                           o_pwt_irq,
  output logic                           o_low_power
);

  typedef struct packed {
    lpw_pkg::mode_e_t     mode;
    logic [11:0]          rec_cnt;
    logic [15:0]          vec;
    logic                 is_reset;
    logic [7:0]           hi;
    logic [15:0]          pc;
    logic                 pc_load;
    logic                 int_mask;
    lpw_pkg::fetch_t      fetch;
    logic                 irq_prev;
    logic [KBD_PINS-1:0]  kbd_prev;
    logic                 irq_pend;
    logic                 kbd_pin_pend;
    logic                 pwt_pend;
    logic [PWT_W-1:0]     pwt_cnt;
  } lpw_st_t;

  localparam logic [PWT_W-1:0] PWT_TERM = '1;

  logic                     rst_meta_ff;
  logic                     rst_n;
  logic                     rst_pin_lvl;
  logic                     irq_lvl;
  logic [KBD_PINS-1:0]      kbd_lvl;
  lpw_st_t                  st_ff;
  lpw_st_t                  nxt_st;
  logic                     in_stop;
  logic                     irq_fall;
  logic                     kbd_fall;
  logic                     pwt_run;
  logic                     pwt_roll;
  logic                     reset_src;
  logic [lpw_pkg::NUM_INT-1:0] int_req;
  logic [lpw_pkg::NUM_INT-1:0] wake_req;
  logic                     any_wake;
  logic [4:0]               sel_idx;
  logic [15:0]              sel_vec;

  // reset release through two flops
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rst_meta_ff <= 1'b0;
      rst_n       <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_n       <= rst_meta_ff;
    end
  end

  pin_sync3 #(
    .W       (2 + KBD_PINS),
    .RST_VAL ({(2 + KBD_PINS){lpw_pkg::RST_PIN_IDLE}})
  ) u_pin_sync (
    .i_clk   (i_clk),
    .i_rst_n (rst_n),
    .i_pin   ({i_reset_pin_n, i_irq_pin_n, i_kbd_pin_n}),
    .o_level ({rst_pin_lvl, irq_lvl, kbd_lvl})
  );

  assign in_stop  = (st_ff.mode == lpw_pkg::MODE_STOP) || (st_ff.mode == lpw_pkg::MODE_RECOVER);
  assign irq_fall = st_ff.irq_prev & ~irq_lvl;
  assign kbd_fall = |(st_ff.kbd_prev & ~kbd_lvl & i_kbd_pin_en);
  // timer freezes in stop unless the oscillator is kept alive
  assign pwt_run  = i_pwt_enable & (~in_stop | i_osc_run_in_stop);
  assign pwt_roll = pwt_run & (st_ff.pwt_cnt == PWT_TERM);

  // watchdog clock is off in stop, so its timeout only counts outside stop
  assign reset_src = ~rst_pin_lvl | i_src.lvr_req
                   | (i_src.wdog_timeout & ~in_stop);

  always_comb
  begin
    int_req                       = '0;
    int_req[lpw_pkg::IDX_BREAK]   = i_src.break_req;
    int_req[lpw_pkg::IDX_IRQ]     = st_ff.irq_pend;
    int_req[lpw_pkg::IDX_CGU]     = i_src.cgu_req;
    int_req[lpw_pkg::IDX_T1_CH0]  = i_src.first_timer_req[0];
    int_req[lpw_pkg::IDX_T1_CH1]  = i_src.first_timer_req[1];
    int_req[lpw_pkg::IDX_T1_OVF]  = i_src.first_timer_req[2];
    int_req[lpw_pkg::IDX_T2_CH0]  = i_src.second_timer_req[0];
    int_req[lpw_pkg::IDX_T2_CH1]  = i_src.second_timer_req[1];
    int_req[lpw_pkg::IDX_T2_OVF]  = i_src.second_timer_req[2];
    int_req[lpw_pkg::IDX_SPI_RX]  = i_src.spi_req[1];
    int_req[lpw_pkg::IDX_SPI_TX]  = i_src.spi_req[0];
    int_req[lpw_pkg::IDX_SCI_ERR] = i_src.sci_req[2];
    int_req[lpw_pkg::IDX_SCI_RX]  = i_src.sci_req[1];
    int_req[lpw_pkg::IDX_SCI_TX]  = i_src.sci_req[0];
    int_req[lpw_pkg::IDX_KBD]     = in_stop ? st_ff.kbd_pin_pend
                                            : (i_src.kbd_req | st_ff.kbd_pin_pend);
    int_req[lpw_pkg::IDX_ADC]     = i_src.adc_req;
    int_req[lpw_pkg::IDX_PWT]     = st_ff.pwt_pend;
  end

  // module requests other than break cannot end stop, their clocks are gone
  assign wake_req = in_stop ? (int_req & lpw_pkg::STOP_WAKE_MASK) : int_req;
  assign any_wake = |wake_req;

  // scan from lowest priority so the lowest index is left selected
  always_comb
  begin
    sel_idx = 5'd0;
    for (int i = lpw_pkg::NUM_INT - 1; i >= 0; i--)
    begin
      if (wake_req[i])
      begin
        sel_idx = 5'(i);
      end
    end
    sel_vec = lpw_pkg::INT_VEC_TABLE[sel_idx];
  end

  always_comb
  begin
    nxt_st            = st_ff;
    nxt_st.pc_load    = 1'b0;
    nxt_st.irq_prev   = irq_lvl;
    nxt_st.kbd_prev   = kbd_lvl;
    nxt_st.pwt_cnt    = pwt_run ? st_ff.pwt_cnt + 1'b1 : st_ff.pwt_cnt;

    unique case (st_ff.mode)
      lpw_pkg::MODE_RUN:
      begin
        if (reset_src)
        begin
          nxt_st.mode     = lpw_pkg::MODE_FETCH_HI;
          nxt_st.vec      = lpw_pkg::VEC_RESET;
          nxt_st.is_reset = 1'b1;
          nxt_st.fetch    = '{rd: 1'b1, addr: lpw_pkg::VEC_RESET};
        end
        else if (i_stop_req)
        begin
          nxt_st.mode     = lpw_pkg::MODE_STOP;
          nxt_st.int_mask = 1'b0;
        end
        else if (i_wait_req)
        begin
          nxt_st.mode     = lpw_pkg::MODE_WAIT;
          nxt_st.int_mask = 1'b0;
        end
      end
      lpw_pkg::MODE_WAIT:
      begin
        if (reset_src || any_wake)
        begin
          nxt_st.mode     = lpw_pkg::MODE_FETCH_HI;
          nxt_st.is_reset = reset_src;
          nxt_st.vec      = reset_src ? lpw_pkg::VEC_RESET : sel_vec;
          nxt_st.fetch    = '{rd: 1'b1, addr: reset_src ? lpw_pkg::VEC_RESET : sel_vec};
        end
      end
      lpw_pkg::MODE_STOP:
      begin
        if (reset_src || any_wake)
        begin
          nxt_st.mode     = lpw_pkg::MODE_RECOVER;
          nxt_st.is_reset = reset_src;
          nxt_st.vec      = reset_src ? lpw_pkg::VEC_RESET : sel_vec;
          nxt_st.rec_cnt  = i_short_recovery_select ? lpw_pkg::REC_SHORT_LOAD
                                                    : lpw_pkg::REC_LONG_LOAD;
        end
      end
      lpw_pkg::MODE_RECOVER:
      begin
        // a reset during hold-off upgrades the vector, the count runs on
        if (reset_src)
        begin
          nxt_st.is_reset = 1'b1;
          nxt_st.vec      = lpw_pkg::VEC_RESET;
        end
        if (st_ff.rec_cnt == 12'h000)
        begin
          nxt_st.mode  = lpw_pkg::MODE_FETCH_HI;
          nxt_st.fetch = '{rd: 1'b1, addr: reset_src ? lpw_pkg::VEC_RESET : st_ff.vec};
        end
        else
        begin
          nxt_st.rec_cnt = st_ff.rec_cnt - 12'h001;
        end
      end
      lpw_pkg::MODE_FETCH_HI:
      begin
        nxt_st.mode  = lpw_pkg::MODE_FETCH_LO;
        nxt_st.fetch = '{rd: 1'b1, addr: {st_ff.vec[15:1], 1'b1}};
      end
      lpw_pkg::MODE_FETCH_LO:
      begin
        nxt_st.mode  = lpw_pkg::MODE_CAPTURE;
        nxt_st.hi    = i_vec_data;
        nxt_st.fetch = '{rd: 1'b0, addr: st_ff.fetch.addr};
      end
      lpw_pkg::MODE_CAPTURE:
      begin
        nxt_st.mode     = lpw_pkg::MODE_RUN;
        nxt_st.pc       = {st_ff.hi, i_vec_data};
        nxt_st.pc_load  = 1'b1;
        nxt_st.is_reset = 1'b0;
        if (st_ff.is_reset)
        begin
          nxt_st.int_mask = 1'b1;
        end
      end
    endcase

    // edge latches: a new edge in the clearing cycle keeps the flag set
    if (st_ff.mode == lpw_pkg::MODE_WAIT || st_ff.mode == lpw_pkg::MODE_STOP)
    begin
      if (!reset_src && any_wake && sel_idx == 5'(lpw_pkg::IDX_IRQ))
      begin
        nxt_st.irq_pend = 1'b0;
      end
      if (!reset_src && any_wake && sel_idx == 5'(lpw_pkg::IDX_KBD))
      begin
        nxt_st.kbd_pin_pend = 1'b0;
      end
      if (!reset_src && any_wake && sel_idx == 5'(lpw_pkg::IDX_PWT))
      begin
        nxt_st.pwt_pend = 1'b0;
      end
    end
    if (irq_fall)
    begin
      nxt_st.irq_pend = 1'b1;
    end
    if (kbd_fall)
    begin
      nxt_st.kbd_pin_pend = 1'b1;
    end
    if (pwt_roll)
    begin
      nxt_st.pwt_pend = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff          <= '0;
      st_ff.mode     <= lpw_pkg::MODE_RUN;
      st_ff.int_mask <= lpw_pkg::RST_INT_MASK;
      st_ff.irq_prev <= lpw_pkg::RST_PIN_IDLE;
      st_ff.kbd_prev <= {KBD_PINS{lpw_pkg::RST_PIN_IDLE}};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign o_fetch      = st_ff.fetch;
  assign o_pc         = st_ff.pc;
  assign o_pc_load    = st_ff.pc_load;
  assign o_int_mask   = st_ff.int_mask;
  assign o_core_reset = st_ff.is_reset;
  assign o_pwt_irq    = st_ff.pwt_pend;
  assign o_cpu_clk_en = (st_ff.mode == lpw_pkg::MODE_RUN);
  assign o_sys_clk_en = ~in_stop;
  assign o_aux_clk_en = ~in_stop | i_osc_run_in_stop;
  assign o_low_power  = (st_ff.mode == lpw_pkg::MODE_WAIT) | in_stop;

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_n);

  logic [11:0] rec_cyc_ff;
  logic        rec_short_ff;

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rec_cyc_ff   <= 12'h000;
      rec_short_ff <= 1'b0;
    end
    else if (st_ff.mode == lpw_pkg::MODE_RECOVER)
    begin
      rec_cyc_ff <= rec_cyc_ff + 12'h001;
    end
    else
    begin
      rec_cyc_ff   <= 12'h000;
      rec_short_ff <= i_short_recovery_select;
    end
  end

  sequence s_vec_fetch(logic [15:0] v);
    o_fetch.rd && o_fetch.addr == v ##1 o_fetch.rd && o_fetch.addr == {$past(o_fetch.addr[15:1]), 1'b1};
  endsequence

  sequence s_pc_done;
    st_ff.mode == lpw_pkg::MODE_CAPTURE ##1 o_pc_load && o_cpu_clk_en;
  endsequence

  AST_WAIT_WAKE: assert property (st_ff.mode == lpw_pkg::MODE_WAIT && any_wake && !reset_src
    |=> s_vec_fetch($past(sel_vec)) ##1 s_pc_done)
    else $error("wait wake did not fetch selected vector and restart cpu clock");
  AST_RESET_VEC: assert property (st_ff.mode == lpw_pkg::MODE_WAIT && reset_src
    |=> s_vec_fetch(lpw_pkg::VEC_RESET))
    else $error("reset in wait did not fetch reset vector");
  AST_BREAK_VEC: assert property (st_ff.mode == lpw_pkg::MODE_WAIT && i_src.break_req && !reset_src
    |=> o_fetch.addr == lpw_pkg::VEC_BREAK)
    else $error("break did not win the interrupt priority");
  AST_STOP_HOLD: assert property (st_ff.mode == lpw_pkg::MODE_STOP && !reset_src && !any_wake
    |=> st_ff.mode == lpw_pkg::MODE_STOP && !o_sys_clk_en)
    else $error("stop mode left without a permitted event");
  AST_REC_LEN: assert property (st_ff.mode == lpw_pkg::MODE_RECOVER && st_ff.rec_cnt == 12'h000
    |-> rec_cyc_ff == (rec_short_ff ? lpw_pkg::REC_SHORT_LOAD : lpw_pkg::REC_LONG_LOAD))
    else $error("stop recovery hold-off has wrong length");
  AST_REC_CLK: assert property ($rose(st_ff.mode == lpw_pkg::MODE_RECOVER) && i_short_recovery_select
    |-> !o_sys_clk_en [*8])
    else $error("system clocks released during short recovery");
  AST_MASK_CLR: assert property (st_ff.mode == lpw_pkg::MODE_RUN && !reset_src
    && (i_stop_req || i_wait_req) |=> !o_int_mask && o_low_power)
    else $error("interrupt mask not cleared on low-power entry");
  AST_MASK_SET: assert property (st_ff.mode == lpw_pkg::MODE_CAPTURE && st_ff.is_reset
    |=> o_int_mask && o_pc_load)
    else $error("interrupt mask not set after reset exit");
  AST_AUX_GATE: assert property (st_ff.mode == lpw_pkg::MODE_STOP && !i_osc_run_in_stop
    |-> !o_aux_clk_en && !pwt_run)
    else $error("auxiliary clocks running in stop without oscillator");
  AST_PC_BYTES: assert property (st_ff.mode == lpw_pkg::MODE_FETCH_LO
    |=> ##1 o_pc == {$past(i_vec_data, 2), $past(i_vec_data)})
    else $error("vector bytes assembled in wrong order");
  AST_PWT_ROLL: assert property (pwt_roll |=> o_pwt_irq)
    else $error("periodic timer rollover did not raise its interrupt");

endmodule : low_power_wake_vectoring

`default_nettype wire

// File: vec_mem_model.sv
// Purpose: vector memory partner, one byte a read
// Assumes: read data due one cycle after o_fetch.rd
// Notes:   idle data toggles so stale bytes never match
`timescale 1ns/100ps
`default_nettype none
module vec_mem_model (
  // clock and fetch request
  input  wire logic            i_clk,
  input  wire lpw_pkg::fetch_t i_fetch,
  // read data
  output var  logic [7:0]      o_data = 8'h00
);
  // byte per address, even address is the high byte
  always_ff @(posedge i_clk)
    o_data <= i_fetch.rd ? (i_fetch.addr[7:0] ^ 8'hA5) : ~o_data;
endmodule : vec_mem_model
`default_nettype wire

// File: tb.sv
// Purpose: self-checking bench for wake and vectoring
// Assumes: reset pin and pin enables tied
// Notes:   recovery length measured on o_sys_clk_en, stop dwell before the wake included
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic i_clk = 0, i_reset_n = 0, i_irq_pin_n = 1, i_sr = 0, i_wait_req = 0, i_stop_req = 0;
  logic i_osc = 0, i_pwt_en = 0;
  logic [7:0] i_kbd_pin_n = 8'hFF, vdat;
  lpw_pkg::wake_src_t i_src = '0;
  lpw_pkg::fetch_t o_fetch;
  logic [15:0] o_pc;
  logic o_pc_load, o_int_mask, o_sys_clk_en;
  logic o_core_reset, o_cpu_clk_en, o_aux_clk_en, o_pwt_irq, o_low_power;
  logic [16:0] exp_q[$];
  int error_cnt = 0, total_checks = 0;
  logic [31:0] rs = 32'h0000_C002;
  // source index to packed request bit, -1 for the irq pin and the periodic timer
  int bp[17] = '{16, -1, 15, 11, 12, 13, 8, 9, 10, 7, 6, 5, 4, 3, 14, 2, -1};
  logic [15:0] vt[17] = '{16'hFFFC, 16'hFFFA, 16'hFFF8, 16'hFFF6, 16'hFFF4, 16'hFFF2, 16'hFFF0,
    16'hFFEE, 16'hFFEC, 16'hFFEA, 16'hFFE8, 16'hFFE6, 16'hFFE4, 16'hFFE2, 16'hFFE0, 16'hFFDE, 16'hFFDC};
  low_power_wake_vectoring #(.KBD_PINS(8), .PWT_W(4)) dut (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_reset_pin_n(1'b1), .i_irq_pin_n(i_irq_pin_n), .i_kbd_pin_n(i_kbd_pin_n), .i_kbd_pin_en(8'hFF),
    .i_short_recovery_select(i_sr), .i_osc_run_in_stop(i_osc), .i_pwt_enable(i_pwt_en),
    .i_wait_req(i_wait_req), .i_stop_req(i_stop_req), .i_vec_data(vdat), .i_src(i_src),
    .o_fetch(o_fetch), .o_pc(o_pc), .o_pc_load(o_pc_load), .o_int_mask(o_int_mask),
    .o_core_reset(o_core_reset), .o_cpu_clk_en(o_cpu_clk_en), .o_sys_clk_en(o_sys_clk_en),
    .o_aux_clk_en(o_aux_clk_en), .o_pwt_irq(o_pwt_irq), .o_low_power(o_low_power));
  vec_mem_model mem (.i_clk(i_clk), .i_fetch(o_fetch), .o_data(vdat));
  function automatic logic [7:0] mb(input logic [15:0] a);
    return a[7:0] ^ 8'hA5;
  endfunction : mb
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction : xs
  task automatic chk(input logic [16:0] e, input logic [16:0] g);
    total_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  task automatic final_report;
    chk(17'h0_0000, 17'(exp_q.size()));
    if (error_cnt == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report
  // enter wait or stop, raise sources and pins, release once fetch starts
  task automatic wake(input logic stp, input logic [16:0] s, input logic [8:0] p,
                      input logic [15:0] v, input logic m, input int rec);
    int n;
    int k;
    n = 0;
    k = 0;
    @(posedge i_clk);
    {i_stop_req, i_wait_req} <= {stp, !stp};
    @(posedge i_clk);
    {i_stop_req, i_wait_req} <= 2'b00;
    i_src <= s;
    {i_irq_pin_n, i_kbd_pin_n} <= ~p;
    exp_q.push_back({m, mb(v), mb(v | 16'h0001)});
    while (o_fetch.rd !== 1'b1 && k < 5000)
    begin
      @(posedge i_clk);
      k++;
      n += (o_sys_clk_en === 1'b0);
    end
    i_src <= '0;
    {i_irq_pin_n, i_kbd_pin_n} <= 9'h1FF;
    // pin events first pass the three-flop filter and edge latch while still stopped
    if (rec > 0)
      chk(17'(rec + ((p != 9'h000) ? 6 : 1)), 17'(n));
    // fetch under way: cpu clock still off, low power left, reset flag only for reset wakes
    chk({13'h0000, m, 3'b001}, {13'h0000, o_core_reset, o_cpu_clk_en, o_low_power, o_aux_clk_en});
    chk(17'h0_0000, {16'h0000, o_pwt_irq & ~i_pwt_en});
    repeat (8) @(posedge i_clk);
  endtask : wake
  initial forever #2 i_clk = ~i_clk;
  // results pair with the oldest note; an empty queue forces a mismatch
  always @(posedge i_clk)
    if (o_pc_load === 1'b1)
      chk(exp_q.size() ? exp_q.pop_front() : 'x, {o_int_mask, o_pc});
  initial
  begin
    repeat (8) @(posedge i_clk);
    i_reset_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    // each module source in wait, a lower adc request sometimes pending too
    for (int i = 0; i < 17; i++)
      if (bp[i] >= 0)
      begin
        rs = xs(rs);
        wake(0, (17'h0_0001 << bp[i]) | ((i < 15 && rs[0]) ? 17'h0_0004 : 17'h0_0000), 9'h000, vt[i], 0, 0);
      end
    wake(0, 17'h0_0000, 9'h100, 16'hFFFA, 0, 0);
    wake(0, 17'h0_0002, 9'h000, 16'hFFFE, 1, 0);
    wake(0, 17'h0_8001, 9'h000, 16'hFFFE, 1, 0);
    i_sr <= 1'b0; // full delay kept as for a crystal
    wake(1, 17'h0_0000, 9'h100, 16'hFFFA, 0, 4096);
    i_sr <= 1'b1;
    wake(1, 17'h0_8000, 9'h001, 16'hFFE0, 0, 32);
    wake(1, 17'h1_0002, 9'h000, 16'hFFFC, 0, 32);
    wake(1, 17'h0_0001, 9'h000, 16'hFFFE, 1, 32);
    // periodic timer last: its pending flag may be left set by a later rollover
    {i_osc, i_pwt_en} <= 2'b11;
    wake(0, 17'h0_0000, 9'h000, 16'hFFDC, 0, 0);
    wake(1, 17'h0_0000, 9'h000, 16'hFFDC, 0, 0);
    final_report();
  end
  initial
  begin
    #100000;
    error_cnt++;
    final_report();
  end
endmodule : tb
`default_nettype wire
